// [src/rvc_bank.sv]
// Purpose: Byte-wide voltage code registers for rails five and six and two linear regulators.
// Assumes: The serial management port presents decoded byte reads and writes on clk.
// Notes: Contents load from factory defaults on the first edge after reset release.
//
// Behaviour
// - Rail five sleep code in bits 7:1.
// - Offset 98h bits 7:1 rail six normal code.
// - Bit 0 clear: actively slew down.
// - Bit 0 set: passive decay down.
// - Offset 99h rail six sleep code, bit0 reserved.
// - Offset 9Ah bits 7:4 linear two sleep.
// - Offset 9Ah bits 3:0 linear two normal.
// - Offset 9Bh bits 7:4 linear three sleep.
// - Offset 9Bh bits 3:0 linear three normal.
// - Sleep code when enabled and pin low.

`timescale 1ns/1ns
`default_nettype none

module rvc_bank #(
    parameter int unsigned NPIN = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register access from the serial management port.
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [rvc_pkg::ADDR_W-1:0] addr,
    input wire logic [rvc_pkg::DATA_W-1:0] wr_data,
    output logic [rvc_pkg::DATA_W-1:0] rd_data_ff,
    output logic rd_valid_ff,
    // Factory configuration.
    input wire rvc_pkg::rvc_defaults_t factory_defaults,
    input wire rvc_pkg::rvc_sleep_cfg_t rail5_sleep_cfg,
    input wire rvc_pkg::rvc_sleep_cfg_t rail6_sleep_cfg,
    input wire rvc_pkg::rvc_sleep_cfg_t lin2_sleep_cfg,
    input wire rvc_pkg::rvc_sleep_cfg_t lin3_sleep_cfg,
    // Sleep control pins and rail five's normal code held elsewhere.
    input wire logic [NPIN-1:0] sleep_pins,
    input wire logic [rvc_pkg::STEP_CODE_W-1:0] rail5_normal_code,
    // Regulator targets.
    output logic [rvc_pkg::STEP_CODE_W-1:0] rail5_target_ff,
    output logic [rvc_pkg::STEP_CODE_W-1:0] rail6_target_ff,
    output logic [rvc_pkg::LIN_CODE_W-1:0] aux_linear2_target_ff,
    output logic [rvc_pkg::LIN_CODE_W-1:0] aux_linear3_target_ff,
    // Rail six fall behaviour and sleep state.
    output logic rail6_passive_fall_select_ff,
    output logic rail6_in_sleep_ff,
    // High while the bank still holds reset constants.
    output logic loading_ff
);

    // ************************************************************
    // Checks
    // ************************************************************

    // One pin select bit can address at most two pins.
    initial begin
        if (NPIN < 1 || NPIN > 2) begin
            $error("rvc_bank: NPIN must be 1 or 2");
        end
    end

    // ************************************************************
    // Storage
    // ************************************************************

    // Step down rail codes.
    logic [rvc_pkg::STEP_CODE_W-1:0] rail5_sleep_target_ff;
    logic [rvc_pkg::STEP_CODE_W-1:0] rail6_normal_target_ff;
    logic [rvc_pkg::STEP_CODE_W-1:0] rail6_sleep_target_ff;
    // Rail six fall mode: zero slews actively, one decays passively.
    logic rail6_fall_ff;
    // Linear regulator codes.
    logic [rvc_pkg::LIN_CODE_W-1:0] aux_linear2_sleep_target_ff;
    logic [rvc_pkg::LIN_CODE_W-1:0] aux_linear2_normal_target_ff;
    logic [rvc_pkg::LIN_CODE_W-1:0] aux_linear3_sleep_target_ff;
    logic [rvc_pkg::LIN_CODE_W-1:0] aux_linear3_normal_target_ff;
    // Sleep state of the other rails; kept for visibility, not driven out.
    logic rail5_in_sleep;
    logic lin2_in_sleep;
    logic lin3_in_sleep;

    // Tests whether an address matches a given offset.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ************************************************************
    // Factory load
    // ************************************************************

    // The asynchronous reset may only load constants, so the factory values are
    // caught by this flag on the first edge after release.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loading_ff <= 1'b1;
        end else begin
            loading_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************

    // Rail five sleep code; writes during the load cycle lose to the defaults.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rail5_sleep_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::STEP_CODE_W-1:0];
        end else if (loading_ff) begin
            rail5_sleep_target_ff <= factory_defaults.rail5_sleep;
        end else if (wr_en && hit(addr, rvc_pkg::OFS_RAIL5_SLEEP_CODE)) begin
            rail5_sleep_target_ff <= wr_data[rvc_pkg::STEP_CODE_LSB +: rvc_pkg::STEP_CODE_W];
        end
    end

    // Rail six normal code and its fall mode bit.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rail6_normal_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::STEP_CODE_W-1:0];
            rail6_fall_ff <= rvc_pkg::RESET_BYTE[0];
        end else if (loading_ff) begin
            rail6_normal_target_ff <= factory_defaults.rail6_normal;
            rail6_fall_ff <= factory_defaults.rail6_fall;
        end else if (wr_en && hit(addr, rvc_pkg::OFS_RAIL6_NORMAL_CODE)) begin
            rail6_normal_target_ff <= wr_data[rvc_pkg::STEP_CODE_LSB +: rvc_pkg::STEP_CODE_W];
            rail6_fall_ff <= wr_data[rvc_pkg::FALL_SEL_BIT];
        end
    end

    // Rail six sleep code; bit 0 of the write is dropped, it is reserved.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rail6_sleep_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::STEP_CODE_W-1:0];
        end else if (loading_ff) begin
            rail6_sleep_target_ff <= factory_defaults.rail6_sleep;
        end else if (wr_en && hit(addr, rvc_pkg::OFS_RAIL6_SLEEP_CODE)) begin
            rail6_sleep_target_ff <= wr_data[rvc_pkg::STEP_CODE_LSB +: rvc_pkg::STEP_CODE_W];
        end
    end

    // Second auxiliary linear regulator: sleep nibble high, normal nibble low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_linear2_sleep_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::LIN_CODE_W-1:0];
            aux_linear2_normal_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::LIN_CODE_W-1:0];
        end else if (loading_ff) begin
            aux_linear2_sleep_target_ff <= factory_defaults.lin2_sleep;
            aux_linear2_normal_target_ff <= factory_defaults.lin2_normal;
        end else if (wr_en && hit(addr, rvc_pkg::OFS_AUX_LINEAR2_CODES)) begin
            aux_linear2_sleep_target_ff <= wr_data[rvc_pkg::LIN_SLEEP_LSB +: rvc_pkg::LIN_CODE_W];
            aux_linear2_normal_target_ff <= wr_data[rvc_pkg::LIN_NORMAL_LSB +: rvc_pkg::LIN_CODE_W];
        end
    end

    // Third auxiliary linear regulator: same layout as the second.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_linear3_sleep_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::LIN_CODE_W-1:0];
            aux_linear3_normal_target_ff <= rvc_pkg::RESET_BYTE[rvc_pkg::LIN_CODE_W-1:0];
        end else if (loading_ff) begin
            aux_linear3_sleep_target_ff <= factory_defaults.lin3_sleep;
            aux_linear3_normal_target_ff <= factory_defaults.lin3_normal;
        end else if (wr_en && hit(addr, rvc_pkg::OFS_AUX_LINEAR3_CODES)) begin
            aux_linear3_sleep_target_ff <= wr_data[rvc_pkg::LIN_SLEEP_LSB +: rvc_pkg::LIN_CODE_W];
            aux_linear3_normal_target_ff <= wr_data[rvc_pkg::LIN_NORMAL_LSB +: rvc_pkg::LIN_CODE_W];
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************

    // Read data for this cycle's address.
    logic [rvc_pkg::DATA_W-1:0] nxt_rd_data;

    // Reserved bits read as zero; unmapped addresses return zero so the port
    // never reflects stale data.
    always_comb begin
        nxt_rd_data = rvc_pkg::READ_ZERO;
        if (hit(addr, rvc_pkg::OFS_RAIL5_SLEEP_CODE)) begin
            nxt_rd_data = {rail5_sleep_target_ff, rvc_pkg::RESERVED_BIT_VAL};
        end else if (hit(addr, rvc_pkg::OFS_RAIL6_NORMAL_CODE)) begin
            nxt_rd_data = {rail6_normal_target_ff, rail6_fall_ff};
        end else if (hit(addr, rvc_pkg::OFS_RAIL6_SLEEP_CODE)) begin
            nxt_rd_data = {rail6_sleep_target_ff, rvc_pkg::RESERVED_BIT_VAL};
        end else if (hit(addr, rvc_pkg::OFS_AUX_LINEAR2_CODES)) begin
            nxt_rd_data = {aux_linear2_sleep_target_ff, aux_linear2_normal_target_ff};
        end else if (hit(addr, rvc_pkg::OFS_AUX_LINEAR3_CODES)) begin
            nxt_rd_data = {aux_linear3_sleep_target_ff, aux_linear3_normal_target_ff};
        end
    end

    // Read data is held until the next read; valid marks it for one cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= rvc_pkg::READ_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    // ************************************************************
    // Fall mode
    // ************************************************************

    // The regulator slews actively when low and lets the output decay when high;
    // in decay the fall rate is set by the load, not by this logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rail6_passive_fall_select_ff <= 1'b0;
        end else begin
            rail6_passive_fall_select_ff <= rail6_fall_ff;
        end
    end

    // ************************************************************
    // Target selection
    // ************************************************************

    // Rail five: only its sleep code lives here.
    rvc_target_sel #(.CODE_W(rvc_pkg::STEP_CODE_W), .NPIN(NPIN)) u_sel_rail5 (
        .clk(clk),
        .rst(rst),
        .normal_code(rail5_normal_code),
        .sleep_code(rail5_sleep_target_ff),
        .sleep_cfg(rail5_sleep_cfg),
        .sleep_pins(sleep_pins),
        .target_ff(rail5_target_ff),
        .in_sleep_ff(rail5_in_sleep)
    );

    // Rail six.
    rvc_target_sel #(.CODE_W(rvc_pkg::STEP_CODE_W), .NPIN(NPIN)) u_sel_rail6 (
        .clk(clk),
        .rst(rst),
        .normal_code(rail6_normal_target_ff),
        .sleep_code(rail6_sleep_target_ff),
        .sleep_cfg(rail6_sleep_cfg),
        .sleep_pins(sleep_pins),
        .target_ff(rail6_target_ff),
        .in_sleep_ff(rail6_in_sleep_ff)
    );

    // Second auxiliary linear regulator.
    rvc_target_sel #(.CODE_W(rvc_pkg::LIN_CODE_W), .NPIN(NPIN)) u_sel_lin2 (
        .clk(clk),
        .rst(rst),
        .normal_code(aux_linear2_normal_target_ff),
        .sleep_code(aux_linear2_sleep_target_ff),
        .sleep_cfg(lin2_sleep_cfg),
        .sleep_pins(sleep_pins),
        .target_ff(aux_linear2_target_ff),
        .in_sleep_ff(lin2_in_sleep)
    );

    // Third auxiliary linear regulator.
    rvc_target_sel #(.CODE_W(rvc_pkg::LIN_CODE_W), .NPIN(NPIN)) u_sel_lin3 (
        .clk(clk),
        .rst(rst),
        .normal_code(aux_linear3_normal_target_ff),
        .sleep_code(aux_linear3_sleep_target_ff),
        .sleep_cfg(lin3_sleep_cfg),
        .sleep_pins(sleep_pins),
        .target_ff(aux_linear3_target_ff),
        .in_sleep_ff(lin3_in_sleep)
    );

endmodule : rvc_bank

`default_nettype wire

// [src/rvc_pkg.sv]
// Purpose: Shared constants and carriers for the rail voltage code register bank.
// Assumes: Byte-wide registers reached through the serial management port's register access.
// Notes: Factory defaults arrive as a struct from the non-volatile configuration.

package rvc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************

    // Address width of the management port's register space.
    localparam int unsigned ADDR_W = 8;
    // Data width of every register.
    localparam int unsigned DATA_W = 8;

    // Sleep code of step down rail five.
    localparam logic [7:0] OFS_RAIL5_SLEEP_CODE = 8'h97;
    // Normal code and fall mode of step down rail six.
    localparam logic [7:0] OFS_RAIL6_NORMAL_CODE = 8'h98;
    // Sleep code of step down rail six.
    localparam logic [7:0] OFS_RAIL6_SLEEP_CODE = 8'h99;
    // Sleep and normal codes of the second auxiliary linear regulator.
    localparam logic [7:0] OFS_AUX_LINEAR2_CODES = 8'h9A;
    // Sleep and normal codes of the third auxiliary linear regulator.
    localparam logic [7:0] OFS_AUX_LINEAR3_CODES = 8'h9B;

    // ************************************************************
    // Field layout
    // ************************************************************

    // Step down rail codes are seven bits in bits 7 to 1.
    localparam int unsigned STEP_CODE_W = 7;
    localparam int unsigned STEP_CODE_LSB = 1;
    // Bit 0 of the normal code register selects passive fall.
    localparam int unsigned FALL_SEL_BIT = 0;
    // Linear regulator codes are four bits each.
    localparam int unsigned LIN_CODE_W = 4;
    localparam int unsigned LIN_SLEEP_LSB = 4;
    localparam int unsigned LIN_NORMAL_LSB = 0;
    // Value read from unmapped addresses and held in the read data under reset.
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Value of a reserved read-only bit.
    localparam logic RESERVED_BIT_VAL = 1'b0;
    // Constant held by code registers under asynchronous reset.
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ************************************************************
    // Carriers
    // ************************************************************

    // Factory-programmed reset contents of the bank.
    typedef struct packed {
        logic [6:0] rail5_sleep;
        logic [6:0] rail6_normal;
        logic rail6_fall;
        logic [6:0] rail6_sleep;
        logic [3:0] lin2_sleep;
        logic [3:0] lin2_normal;
        logic [3:0] lin3_sleep;
        logic [3:0] lin3_normal;
    } rvc_defaults_t;

    // Sleep configuration of one rail: enable and the assigned pin index.
    typedef struct packed {
        logic enable;
        logic pin_sel;
    } rvc_sleep_cfg_t;

endpackage : rvc_pkg

// [src/rvc_target_sel.sv]
// Purpose: Picks the normal or sleep code of one rail and registers it as the target.
// Assumes: Sleep pins are synchronous to clk.
// Notes: Sleep applies only when enabled and the assigned pin is low.

`timescale 1ns/1ns
`default_nettype none

module rvc_target_sel #(
    parameter int unsigned CODE_W = 7,
    parameter int unsigned NPIN = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Codes from the bank.
    input wire logic [CODE_W-1:0] normal_code,
    input wire logic [CODE_W-1:0] sleep_code,
    // Sleep configuration and pins.
    input wire rvc_pkg::rvc_sleep_cfg_t sleep_cfg,
    input wire logic [NPIN-1:0] sleep_pins,
    // Target to the regulator and the mode it is in.
    output logic [CODE_W-1:0] target_ff,
    output logic in_sleep_ff
);

    // ************************************************************
    // Checks
    // ************************************************************

    // The pin select is one bit, so at most two sleep pins can be assigned.
    initial begin
        if (CODE_W < 1 || NPIN < 1 || NPIN > 2) begin
            $error("rvc_target_sel: unsupported CODE_W or NPIN");
        end
    end

    // ************************************************************
    // Selection
    // ************************************************************

    // Level of the pin this rail listens to.
    logic pin_level;
    // Sleep decision for this cycle.
    logic nxt_in_sleep;

    // Pin index beyond NPIN falls back to pin zero rather than reading off the end.
    always_comb begin
        pin_level = sleep_pins[0];
        if (NPIN > 1 && sleep_cfg.pin_sel) begin
            pin_level = sleep_pins[NPIN-1];
        end
        nxt_in_sleep = sleep_cfg.enable && !pin_level;
    end

    // Target follows a write to the selected code on the next edge, with no handshake.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_ff <= '0;
            in_sleep_ff <= 1'b0;
        end else begin
            target_ff <= nxt_in_sleep ? sleep_code : normal_code;
            in_sleep_ff <= nxt_in_sleep;
        end
    end

endmodule : rvc_target_sel

`default_nettype wire

// [bench/rvc_bank_checker.sv]
// Purpose: Concurrent checks on the register port, targets and sleep selection of rvc_bank.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes: Bound to every rvc_bank instance by the bind after the module.

`timescale 1ns/1ns
`default_nettype none

module rvc_bank_checker #(
    parameter int unsigned NPIN = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data_ff,
    input wire logic rd_valid_ff,
    // Configuration and pins.
    input wire rvc_pkg::rvc_defaults_t factory_defaults,
    input wire rvc_pkg::rvc_sleep_cfg_t rail6_sleep_cfg,
    input wire rvc_pkg::rvc_sleep_cfg_t lin2_sleep_cfg,
    input wire logic [NPIN-1:0] sleep_pins,
    // Outputs watched.
    input wire logic [6:0] rail6_target_ff,
    input wire logic [3:0] aux_linear2_target_ff,
    input wire logic rail6_passive_fall_select_ff,
    input wire logic rail6_in_sleep_ff,
    input wire logic loading_ff
);
    // ************************************************************
    // Properties
    // ************************************************************

    // All checks share the one clock and the one reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Sleep is requested when enabled and the assigned pin is low.
    wire logic want_sleep;
    assign want_sleep = rail6_sleep_cfg.enable && !sleep_pins[rail6_sleep_cfg.pin_sel ? NPIN-1 : 0];

    read_answer_a: assert property (rd_en |=> rd_valid_ff) else $error("read not answered");
    read_pulse_a: assert property (!rd_en |=> !rd_valid_ff && $stable(rd_data_ff)) else $error("read output moved");
    unmapped_zero_a: assert property (rd_en && (addr < 8'h97 || addr > 8'h9B) |=> rd_data_ff == 8'h00) else $error("unmapped read not zero");
    reserved_bit_a: assert property (rd_en && (addr == 8'h97 || addr == 8'h99) |=> !rd_data_ff[0]) else $error("reserved bit set");
    rail6_write_a: assert property (wr_en && addr == 8'h98 && !loading_ff && !rail6_sleep_cfg.enable
        |=> ##1 rail6_target_ff == $past(wr_data[7:1], 2)) else $error("rail six target wrong");
    fall_write_a: assert property (wr_en && addr == 8'h98 && !loading_ff
        |=> ##1 rail6_passive_fall_select_ff == $past(wr_data[0], 2)) else $error("fall select wrong");
    lin2_write_a: assert property (wr_en && addr == 8'h9A && !loading_ff && !lin2_sleep_cfg.enable
        |=> ##1 aux_linear2_target_ff == $past(wr_data[3:0], 2)) else $error("linear two target wrong");
    sleep_mode_a: assert property (!loading_ff |=> rail6_in_sleep_ff == $past(want_sleep)) else $error("sleep state wrong");
    load_once_a: assert property (loading_ff |=> !loading_ff) else $error("load stuck");
    fall_default_a: assert property ($fell(loading_ff) |=> rail6_passive_fall_select_ff == factory_defaults.rail6_fall) else $error("fall default wrong");
endmodule : rvc_bank_checker

bind rvc_bank rvc_bank_checker #(.NPIN(NPIN)) rvc_bank_checker_inst (.clk(clk), .rst(rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .factory_defaults(factory_defaults), .rail6_sleep_cfg(rail6_sleep_cfg),
    .lin2_sleep_cfg(lin2_sleep_cfg), .sleep_pins(sleep_pins), .rail6_target_ff(rail6_target_ff),
    .aux_linear2_target_ff(aux_linear2_target_ff), .loading_ff(loading_ff),
    .rail6_passive_fall_select_ff(rail6_passive_fall_select_ff), .rail6_in_sleep_ff(rail6_in_sleep_ff));

`default_nettype wire

// [bench/test_rvc_bank.sv]
// Purpose: Self-checking bench for the rail voltage code register bank.
// Assumes: Inputs change at the rising edge by non-blocking assignment.
// Notes: Reads are checked 1 ns after the edge that takes them.

`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module test_rvc_bank;
    // ************************************************************
    // Signals
    // ************************************************************

    logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data_ff;
    logic rd_valid_ff, fall, slp, loading;
    rvc_pkg::rvc_defaults_t dflt = '0;
    rvc_pkg::rvc_sleep_cfg_t c5 = '0, c6 = '0, c2 = '0, c3 = '0;
    logic [1:0] pins = 2'h3;
    logic [6:0] r5n = 7'h5A, t5, t6;
    logic [3:0] t2, t3;
    int n_errors = 0, checks = 0, cycles = 0;

    rvc_bank #(.NPIN(2)) rvc_bank_inst (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .factory_defaults(dflt), .rail5_sleep_cfg(c5), .rail6_sleep_cfg(c6), .lin2_sleep_cfg(c2),
        .lin3_sleep_cfg(c3), .sleep_pins(pins), .rail5_normal_code(r5n), .rail5_target_ff(t5),
        .rail6_target_ff(t6), .aux_linear2_target_ff(t2), .aux_linear3_target_ff(t3),
        .rail6_passive_fall_select_ff(fall), .rail6_in_sleep_ff(slp), .loading_ff(loading));

    // A 50 ns period; the timeout cuts a hang short as a mismatch.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end

    // ************************************************************
    // Port tasks
    // ************************************************************

    // One write strobe, released at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // One read; the answer is looked at just after the taking edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rd_valid", 1'b1, rd_valid_ff)
        `CHK("rd_data", e, rd_data_ff)
    endtask : rd

    // ************************************************************
    // Scenarios
    // ************************************************************

    // Reset with given defaults, then read every register and target.
    task automatic test_defaults(input rvc_pkg::rvc_defaults_t d);
        @(posedge clk);
        rst <= 1'b1;
        dflt <= d;
        {c5, c6, c2, c3} <= '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("loading", 1'b1, loading)
        repeat (3) @(posedge clk);
        #1;
        `CHK("t6", d.rail6_normal, t6)
        `CHK("t5", r5n, t5)
        `CHK("t2", d.lin2_normal, t2)
        `CHK("t3", d.lin3_normal, t3)
        `CHK("fall", d.rail6_fall, fall)
        rd(8'h97, {d.rail5_sleep, 1'b0});
        rd(8'h98, {d.rail6_normal, d.rail6_fall});
        rd(8'h99, {d.rail6_sleep, 1'b0});
        rd(8'h9A, {d.lin2_sleep, d.lin2_normal});
        rd(8'h9B, {d.lin3_sleep, d.lin3_normal});
    endtask : test_defaults

    // Write every register, read back with reserved bits masked, check targets.
    task automatic test_write_read();
        logic [7:0] a[5] = '{8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B};
        logic [7:0] v[5] = '{8'hA5, 8'h81, 8'hFF, 8'h3C, 8'hC3};
        logic [7:0] e[5] = '{8'hA4, 8'h81, 8'hFE, 8'h3C, 8'hC3};
        for (int i = 0; i < 5; i++) begin
            wr(a[i], v[i]);
        end
        for (int i = 0; i < 5; i++) begin
            rd(a[i], e[i]);
        end
        `CHK("t6", 7'h40, t6)
        `CHK("t2", 4'hC, t2)
        `CHK("t3", 4'h3, t3)
        `CHK("fall", 1'b1, fall)
        wr(8'h98, 8'h80);
        @(posedge clk);
        #1;
        `CHK("fall", 1'b0, fall)
        `CHK("t6", 7'h40, t6)
    endtask : test_write_read

    // Unmapped places ignore writes and read as zero.
    task automatic test_unmapped();
        wr(8'h9C, 8'hFF);
        rd(8'h9C, 8'h00);
        rd(8'h96, 8'h00);
        rd(8'h9B, 8'hC3);
    endtask : test_unmapped

    // Sleep applies when enabled and the assigned pin is low; an enabled rail whose pin is high keeps the normal code.
    task automatic test_sleep();
        @(posedge clk);
        c6 <= '{enable: 1'b1, pin_sel: 1'b1};
        c5 <= '{enable: 1'b1, pin_sel: 1'b1};
        c2 <= '{enable: 1'b1, pin_sel: 1'b0};
        c3 <= '{enable: 1'b0, pin_sel: 1'b0};
        pins <= 2'h1;
        @(posedge clk);
        #1;
        `CHK("t6", 7'h7F, t6)
        `CHK("slp", 1'b1, slp)
        `CHK("t5", 7'h52, t5)
        `CHK("t2", 4'hC, t2)
        @(posedge clk);
        pins <= 2'h2;
        c3 <= '{enable: 1'b1, pin_sel: 1'b0};
        @(posedge clk);
        #1;
        `CHK("t6", 7'h40, t6)
        `CHK("slp", 1'b0, slp)
        `CHK("t5", r5n, t5)
        `CHK("t2", 4'h3, t2)
        `CHK("t3", 4'hC, t3)
    endtask : test_sleep

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Main sequence; the second reset reloads other defaults mid-run.
    initial begin
        test_defaults(51'h4_4599_B345_67);
        test_write_read();
        test_unmapped();
        test_sleep();
        test_defaults(51'h3_BA66_4CBA_98);
        summarize();
    end
endmodule : test_rvc_bank

`default_nettype wire
